// File: rtl/sec_status_pkg.sv
// constants, field layout and carriers for the secondary bus status register
package sec_status_pkg;

	localparam logic [7:0]  SEC_STATUS_OFFSET          = 8'h1E;
	localparam logic [15:0] SEC_STATUS_RESET           = 16'h0000;
	localparam int          DETECTED_PARITY_BIT        = 15;
	localparam int          RECEIVED_SYSTEM_ERROR_BIT  = 14;
	localparam int          RECEIVED_MASTER_ABORT_BIT  = 13;
	localparam int          RECEIVED_TARGET_ABORT_BIT  = 12;
	localparam int          SIGNALED_TARGET_ABORT_BIT  = 11;
	localparam int          DECODE_TIMING_LSB          = 9;
	localparam logic [1:0]  DECODE_TIMING_MEDIUM       = 2'h1;
	localparam int          MASTER_DATA_PAR_BIT        = 8;
	localparam int          FAST_B2B_BIT               = 7;
	localparam int          HIGH_SPEED_BIT             = 5;
	localparam int          FLAG_COUNT                 = 6;
	localparam int          UPPER_LANE                 = 1;

	// index of each sticky flag inside the flag vector
	localparam int          FLAG_DETECTED_PARITY  = 5;
	localparam int          FLAG_SYSTEM_ERROR     = 4;
	localparam int          FLAG_MASTER_ABORT     = 3;
	localparam int          FLAG_TARGET_ABORT_RX  = 2;
	localparam int          FLAG_TARGET_ABORT_TX  = 1;
	localparam int          FLAG_MASTER_DATA_PAR  = 0;

	// one-cycle event pulses from the secondary master and target logic
	typedef struct packed {
		logic target_addr_parity_err;
		logic target_write_data_parity_err;
		logic master_read_data_parity_err;
		logic master_abort_end;
		logic target_abort_received;
		logic target_abort_signaled;
		logic master_active;
		logic perr_driven_on_read;
		logic perr_seen_on_write;
	} sec_events_t;

	// configuration access, one 16-bit half word per request
	typedef struct packed {
		logic [7:0]  addr;
		logic        rd;
		logic        wr;
		logic [1:0]  be;
		logic [15:0] wdata;
	} cfg_req_t;

	function automatic logic [15:0] build_status(input logic [FLAG_COUNT-1:0] f);
		logic [15:0] w;
		w = 16'h0000;
		w[DETECTED_PARITY_BIT] = f[FLAG_DETECTED_PARITY];
		w[RECEIVED_SYSTEM_ERROR_BIT] = f[FLAG_SYSTEM_ERROR];
		w[RECEIVED_MASTER_ABORT_BIT] = f[FLAG_MASTER_ABORT];
		w[RECEIVED_TARGET_ABORT_BIT] = f[FLAG_TARGET_ABORT_RX];
		w[SIGNALED_TARGET_ABORT_BIT] = f[FLAG_TARGET_ABORT_TX];
		w[DECODE_TIMING_LSB +: 2] = DECODE_TIMING_MEDIUM;
		w[MASTER_DATA_PAR_BIT] = f[FLAG_MASTER_DATA_PAR];
		w[FAST_B2B_BIT] = 1'h1;
		w[HIGH_SPEED_BIT] = 1'h1;
		return w;
	endfunction

	function automatic logic [FLAG_COUNT-1:0] extract_flags(input logic [15:0] w);
		logic [FLAG_COUNT-1:0] f;
		f = '0;
		f[FLAG_DETECTED_PARITY] = w[DETECTED_PARITY_BIT];
		f[FLAG_SYSTEM_ERROR]    = w[RECEIVED_SYSTEM_ERROR_BIT];
		f[FLAG_MASTER_ABORT]    = w[RECEIVED_MASTER_ABORT_BIT];
		f[FLAG_TARGET_ABORT_RX] = w[RECEIVED_TARGET_ABORT_BIT];
		f[FLAG_TARGET_ABORT_TX] = w[SIGNALED_TARGET_ABORT_BIT];
		f[FLAG_MASTER_DATA_PAR] = w[MASTER_DATA_PAR_BIT];
		return f;
	endfunction

endpackage

// File: rtl/sticky_flags.sv
// sticky event flags with write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module sticky_flags
	import sec_status_pkg::*;
#(
	parameter int WIDTH = FLAG_COUNT
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clear,
	output logic      [WIDTH-1:0] flags
);

	logic [WIDTH-1:0] flags_ff;
	logic [WIDTH-1:0] nxt_flags;

	// an event landing on the clearing write is kept
	assign nxt_flags = (flags_ff & ~clear) | set;
	assign flags     = flags_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

endmodule

// File: rtl/bridge_secondary_status.sv
// secondary bus status register: sticky error flags and fixed capabilities
//
// Overview of operation
// R1 - An address or attribute parity error seen as potential target sets the detected-parity flag.
// R2 - A data parity error seen as target of a write sets the detected-parity flag.
// R3 - A parity error in immediate read data seen as master sets the detected-parity flag.
// R4 - The detected-parity flag is set whatever the parity-response enable says.
// R5 - SERR seen asserted on the secondary bus sets the received-system-error flag.
// R6 - A master abort ending a transaction mastered by the bridge sets the master-abort flag.
// R7 - A target abort received by the bridge as master sets the received-target-abort flag.
// R8 - A target abort signaled by the bridge as target sets the signaled-target-abort flag.
// R9 - The decode-timing field always reads 01b (medium) and ignores writes.
// R10 - The master-data-parity flag sets only as master, with parity response on, on a PERR event.
// R11 - The fast back-to-back capability bit always reads 1.
// R12 - The 66 MHz capability bit always reads 1.
// R13 - Bits 4:0 always read zero.
// R14 - Bit 6 always reads zero.
// R15 - The register sits at configuration offset 1Eh.
// R16 - Capability fields are read-only and event bits are write-one-to-clear.
// R17 - Writing 1 clears an event bit, writing 0 does nothing, otherwise it holds until reset.
`timescale 1ns/1ps
module bridge_secondary_status
	import sec_status_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        SERR_N,
	input  wire logic        PARITY_RESPONSE_ENABLE,
	input  wire sec_events_t SEC_EVENTS,
	input  wire cfg_req_t    CFG_REQ,
	output logic      [15:0] CFG_RDATA,
	output logic             CFG_RVALID
);

	logic                  serr_meta_ff;
	logic                  serr_sync_ff;
	logic [15:0]           rdata_ff;
	logic                  rvalid_ff;
	logic [FLAG_COUNT-1:0] flags;
	logic [FLAG_COUNT-1:0] set_vec;
	logic [FLAG_COUNT-1:0] clear_vec;
	logic [15:0]           nxt_rdata;
	wire                   addr_hit;
	wire                   parity_detect;
	wire                   master_data_par;

	// SERR is a bus pin, so it is synchronised before any use
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			serr_meta_ff <= 1'h1;
			serr_sync_ff <= 1'h1;
		end else begin
			serr_meta_ff <= SERR_N;
			serr_sync_ff <= serr_meta_ff;
		end
	end

	// R15 offset decode
	assign addr_hit = (CFG_REQ.addr == SEC_STATUS_OFFSET);

	// R1 R2 R3 R4 parity enable deliberately not consulted
	assign parity_detect = SEC_EVENTS.target_addr_parity_err
		| SEC_EVENTS.target_write_data_parity_err
		| SEC_EVENTS.master_read_data_parity_err;

	// R10 gated by mastership and parity response
	assign master_data_par = SEC_EVENTS.master_active & PARITY_RESPONSE_ENABLE
		& (SEC_EVENTS.perr_driven_on_read | SEC_EVENTS.perr_seen_on_write);

	// R5 R6 R7 R8 event to flag mapping
	always_comb begin
		set_vec = '0;
		set_vec[FLAG_DETECTED_PARITY] = parity_detect;
		set_vec[FLAG_SYSTEM_ERROR]    = ~serr_sync_ff;
		set_vec[FLAG_MASTER_ABORT]    = SEC_EVENTS.master_abort_end;
		set_vec[FLAG_TARGET_ABORT_RX] = SEC_EVENTS.target_abort_received;
		set_vec[FLAG_TARGET_ABORT_TX] = SEC_EVENTS.target_abort_signaled;
		set_vec[FLAG_MASTER_DATA_PAR] = master_data_par;
	end

	// R16 R17 all event bits live in the upper byte lane
	assign clear_vec = (CFG_REQ.wr & addr_hit & CFG_REQ.be[UPPER_LANE])
		? extract_flags(CFG_REQ.wdata) : '0;

	sticky_flags #(
		.WIDTH (FLAG_COUNT)
	) u_flags (
		.clk   (CORE_CLK),
		.rst   (RST),
		.set   (set_vec),
		.clear (clear_vec),
		.flags (flags)
	);

	// R9 R11 R12 R13 R14 constants come from the image builder
	assign nxt_rdata = (CFG_REQ.rd & addr_hit) ? build_status(flags) : 16'h0000;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rdata_ff  <= SEC_STATUS_RESET;
			rvalid_ff <= 1'h0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= CFG_REQ.rd;
		end
	end

	assign CFG_RDATA  = rdata_ff;
	assign CFG_RVALID = rvalid_ff;

	// checks
	wire hit_rd = CFG_REQ.rd & addr_hit;
	wire upper_wr = CFG_REQ.wr & addr_hit & CFG_REQ.be[UPPER_LANE];

	sequence clear_all_s;
		CFG_REQ.wr && addr_hit && CFG_REQ.be[UPPER_LANE] && (&CFG_REQ.wdata) && (set_vec == '0);
	endsequence

	sequence read_back_s;
		##1 hit_rd ##1 CFG_RVALID;
	endsequence

	tgt_addr_parity_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R1
		SEC_EVENTS.target_addr_parity_err |=> flags[FLAG_DETECTED_PARITY])
		else $error("address parity error did not set detected parity");

	tgt_write_parity_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R2
		SEC_EVENTS.target_write_data_parity_err |=> flags[FLAG_DETECTED_PARITY])
		else $error("write data parity error did not set detected parity");

	mst_read_parity_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R3
		SEC_EVENTS.master_read_data_parity_err |=> flags[FLAG_DETECTED_PARITY])
		else $error("read data parity error did not set detected parity");

	parity_ignores_enable_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R4
		(!PARITY_RESPONSE_ENABLE && parity_detect) |=> flags[FLAG_DETECTED_PARITY])
		else $error("detected parity lost with parity response off");

	serr_capture_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R5
		!SERR_N |-> ##3 flags[FLAG_SYSTEM_ERROR])
		else $error("SERR assertion not recorded");

	master_abort_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R6
		SEC_EVENTS.master_abort_end |=> flags[FLAG_MASTER_ABORT])
		else $error("master abort not recorded");

	target_abort_rx_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R7
		SEC_EVENTS.target_abort_received |=> flags[FLAG_TARGET_ABORT_RX])
		else $error("received target abort not recorded");

	target_abort_tx_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R8
		SEC_EVENTS.target_abort_signaled |=> flags[FLAG_TARGET_ABORT_TX])
		else $error("signaled target abort not recorded");

	decode_timing_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R9
		hit_rd |=> CFG_RDATA[DECODE_TIMING_LSB +: 2] == DECODE_TIMING_MEDIUM)
		else $error("decode timing field not medium");

	data_parity_gate_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R10
		$rose(flags[FLAG_MASTER_DATA_PAR]) |-> $past(master_data_par))
		else $error("master data parity set without its conditions");

	fast_b2b_cap_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R11
		hit_rd |=> CFG_RDATA[FAST_B2B_BIT])
		else $error("fast back-to-back bit not one");

	high_speed_cap_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R12
		hit_rd |=> CFG_RDATA[HIGH_SPEED_BIT])
		else $error("66 MHz bit not one");

	low_reserved_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R13
		hit_rd |=> CFG_RDATA[4:0] == 5'h00)
		else $error("low reserved bits not zero");

	mid_reserved_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R14
		hit_rd |=> !CFG_RDATA[6])
		else $error("reserved bit 6 not zero");

	offset_decode_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R15
		(CFG_REQ.rd && !addr_hit) |=> CFG_RDATA == 16'h0000)
		else $error("read away from the register returned data");

	clear_then_read_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R16
		clear_all_s ##1 (set_vec == '0) ##0 read_back_s |-> CFG_RDATA[15:11] == 5'h00)
		else $error("event bits survived a write of ones");

	flag_holds_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
		(flags != '0) && (clear_vec == '0) |=> (flags & $past(flags)) == $past(flags))
		else $error("event bit dropped without a clearing write");

	data_parity_set_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R10
		master_data_par |=> flags[FLAG_MASTER_DATA_PAR])
		else $error("master data parity event not recorded");

	master_abort_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
		upper_wr && CFG_REQ.wdata[RECEIVED_MASTER_ABORT_BIT] && !SEC_EVENTS.master_abort_end
		|=> !flags[FLAG_MASTER_ABORT])
		else $error("write of one left master abort set");

	parity_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
		upper_wr && CFG_REQ.wdata[DETECTED_PARITY_BIT] && !parity_detect
		|=> !flags[FLAG_DETECTED_PARITY])
		else $error("write of one left detected parity set");

	system_error_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
		upper_wr && CFG_REQ.wdata[RECEIVED_SYSTEM_ERROR_BIT] && serr_sync_ff
		|=> !flags[FLAG_SYSTEM_ERROR])
		else $error("write of one left system error set");

	low_lane_write_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R16
		CFG_REQ.wr && !CFG_REQ.be[UPPER_LANE] |=> (flags & $past(flags)) == $past(flags))
		else $error("low lane write cleared an event bit");

	// no disable here: this one watches the reset itself
	reset_clears_a: assert property (@(posedge CORE_CLK) // R17
		RST |=> (flags == '0) && !CFG_RVALID && (CFG_RDATA == 16'h0000))
		else $error("reset left status state behind");

	read_answer_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R16
		CFG_REQ.rd |=> CFG_RVALID)
		else $error("read gave no valid pulse");

	idle_quiet_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R15
		!CFG_REQ.rd |=> !CFG_RVALID && (CFG_RDATA == 16'h0000))
		else $error("read port active without a read");

endmodule

// File: dv/sec_bus_agent.sv
// far-side bus agent that raises secondary-bus events on command
`timescale 1ns/1ps
module sec_bus_agent
	import sec_status_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [3:0] pick,
	output sec_events_t     ev,
	output logic            serr_n
);
	// every event is a single-cycle pulse, serr included, so a level-held fault never masks a clear
	always @(posedge clk) begin
		ev <= '0;
		serr_n <= 1'h1;
		if (go) begin
			case (pick)
				4'h0: ev.target_addr_parity_err <= 1'h1;
				4'h1: ev.target_write_data_parity_err <= 1'h1;
				4'h2: ev.master_read_data_parity_err <= 1'h1;
				4'h3: ev.master_abort_end <= 1'h1;
				4'h4: ev.target_abort_received <= 1'h1;
				4'h5: ev.target_abort_signaled <= 1'h1;
				4'h6: begin
					ev.master_active <= 1'h1;
					ev.perr_driven_on_read <= 1'h1;
				end
				4'h7: begin
					ev.master_active <= 1'h1;
					ev.perr_seen_on_write <= 1'h1;
				end
				// PERR while some other master owns the bus
				4'h9: ev.perr_seen_on_write <= 1'h1;
				default: serr_n <= 1'h0;
			endcase
		end
	end
endmodule

// File: dv/bridge_secondary_status_bench.sv
// self-checking bench for the secondary bus status register
`timescale 1ns/1ps
module bridge_secondary_status_bench import sec_status_pkg::*;;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        pre = 1'h0;
	logic        go = 1'h0;
	logic [3:0]  pick = 4'h0;
	cfg_req_t    req = '0;
	sec_events_t ev;
	logic        serr_n;
	logic [15:0] rdata;
	logic        rvalid;
	logic [15:0] expq[$];
	logic [31:0] seed;
	logic [31:0] r;
	logic [15:0] m;
	logic [15:0] base;
	int          fails;
	int          n_compared;

	bridge_secondary_status bridge_secondary_status_inst (
		.CORE_CLK(clk), .RST(rst), .SERR_N(serr_n), .PARITY_RESPONSE_ENABLE(pre),
		.SEC_EVENTS(ev), .CFG_REQ(req), .CFG_RDATA(rdata), .CFG_RVALID(rvalid));
	sec_bus_agent sec_bus_agent_inst (.clk(clk), .go(go), .pick(pick), .ev(ev), .serr_n(serr_n));

	initial begin
		seed = 32'h9B92;
		fails = 0;
		n_compared = 0;
		base = 16'h02A0;
	end
	always #20 clk = ~clk;

	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// flag bit each agent command should leave behind
	function automatic logic [15:0] event_bit(input logic [3:0] k, input logic p);
		case (k)
			4'h0, 4'h1, 4'h2: return 16'h8000;
			4'h3: return 16'h2000;
			4'h4: return 16'h1000;
			4'h5: return 16'h0800;
			4'h6, 4'h7: return p ? 16'h0100 : 16'h0000;
			4'h9: return 16'h0000;
			default: return 16'h4000;
		endcase
	endfunction

	task automatic check16(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic cfg(input logic rd, input logic wr, input logic [1:0] b,
			input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{addr: a, rd: rd, wr: wr, be: b, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [15:0] e);
		expq.push_back(e);
		cfg(1'h1, 1'h0, 2'h0, a, 16'h0000);
	endtask

	// six cycles cover the agent register plus the three-edge serr path
	task automatic fire(input logic [3:0] k);
		@(posedge clk);
		go <= 1'h1;
		pick <= k;
		@(posedge clk);
		go <= 1'h0;
		repeat (6) @(posedge clk);
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		if (rvalid === 1'h1) begin
			if (expq.size() == 0) begin
				fails++;
				$display("[FAIL] t=%0t exp=none got=%h", $time, rdata);
			end else
				check16(expq.pop_front(), rdata);
		end
	end

	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		tally_and_finish();
	end

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		rd_check(SEC_STATUS_OFFSET, base);
		rd_check(8'h1C, 16'h0000);
		cfg(1'h0, 1'h1, 2'h3, SEC_STATUS_OFFSET, 16'hFFFF);
		rd_check(SEC_STATUS_OFFSET, base);
		// command 9 is a PERR while the bridge is not master: no flag may follow
		for (int k = 0; k < 10; k++) begin
			r = xorshift();
			@(posedge clk);
			pre <= r[0] ^ k[0];
			m = event_bit(k[3:0], r[0] ^ k[0]);
			fire(k[3:0]);
			rd_check(SEC_STATUS_OFFSET, base | m);
			cfg(1'h0, 1'h1, 2'h1, SEC_STATUS_OFFSET, r[31:16]);
			cfg(1'h0, 1'h1, 2'h2, SEC_STATUS_OFFSET, ~m);
			rd_check(SEC_STATUS_OFFSET, base | m);
			expq.push_back(base | m);
			cfg(1'h1, 1'h1, 2'h2, SEC_STATUS_OFFSET, k[0] ? 16'hFFFF : m);
			rd_check(SEC_STATUS_OFFSET, base);
		end
		// parity with response off, then a mid-run reset must drop the standing flag
		pre <= 1'h0;
		fire(4'h0);
		rd_check(SEC_STATUS_OFFSET, base | 16'h8000);
		@(posedge clk);
		rst <= 1'h1;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd_check(SEC_STATUS_OFFSET, base);
		repeat (4) @(posedge clk);
		if (expq.size() != 0)
			fails++;
		tally_and_finish();
	end
endmodule
